// >>> inc/dtc_defines.vh
// Purpose: Register offsets, field positions and timing counts of the dual timer/counter.
// Assumes: APB word addressing with 32-bit data; 8-bit registers in the low byte.
// Notes:   Oscillator periods per machine cycle match pclk periods.
`ifndef DTC_DEFINES_VH
`define DTC_DEFINES_VH
`define DTC_ADDR_W        12
`define DTC_OFF_CTRL      12'h000
`define DTC_OFF_MODE      12'h004
`define DTC_OFF_T0_LOW    12'h008
`define DTC_OFF_T0_HIGH   12'h00C
`define DTC_OFF_T1_LOW    12'h010
`define DTC_OFF_T1_HIGH   12'h014
`define DTC_OFF_EVT_CLR   12'h018
`define DTC_BIT_TF1       7
`define DTC_BIT_TR1       6
`define DTC_BIT_TF0       5
`define DTC_BIT_TR0       4
`define DTC_BIT_IE1       3
`define DTC_BIT_IT1       2
`define DTC_BIT_IE0       1
`define DTC_BIT_IT0       0
`define DTC_MOD_GATE      3
`define DTC_MOD_CT        2
`define DTC_MOD_M1        1
`define DTC_MOD_M0        0
`define DTC_MODE_13BIT    2'h0
`define DTC_MODE_16BIT    2'h1
`define DTC_MODE_RELOAD   2'h2
`define DTC_MODE_SPLIT    2'h3
`define DTC_OSC_PER_MC    12
`define DTC_MC_W          4
`define DTC_MC_LAST       4'hB
`define DTC_CTRL_RESET    8'h00
`define DTC_MODE_RESET    8'h00
`endif

// >>> hdl/dtc_mc_timebase.v
// Purpose: Machine-cycle strobe, one pclk pulse every twelve oscillator periods.
// Assumes: pclk is the oscillator clock.
// Notes:   Strobe is registered.
`timescale 1ns/10ps
`default_nettype none
`include "dtc_defines.vh"
module dtc_mc_timebase (
   // Clock and reset
   input  wire         pclk,
   input  wire         presetn,
   // Strobe
   output reg          mc_tick_q
);
   reg  [`DTC_MC_W-1:0] cnt_q;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q     <= {`DTC_MC_W{1'b0}};
         mc_tick_q <= 1'b0;
      end else begin
         mc_tick_q <= (cnt_q == `DTC_MC_LAST);
         if (cnt_q == `DTC_MC_LAST) begin
            cnt_q <= {`DTC_MC_W{1'b0}};
         end else begin
            cnt_q <= cnt_q + 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

// >>> hdl/dtc_pin_sampler.v
// Purpose: Once per machine cycle samples a count pin and an interrupt pin, flags falls.
// Assumes: Pins are synchronous to pclk.
// Notes:   Fall pulses are one pclk wide, in the pclk after the machine-cycle strobe that takes the low sample.
`timescale 1ns/10ps
`default_nettype none
module dtc_pin_sampler (
   // Clock and reset
   input  wire         pclk,
   input  wire         presetn,
   // Timing
   input  wire         mc_tick,
   // Pins
   input  wire         count_pin,
   input  wire         irq_pin,
   // Results
   output reg          count_fall_q,
   output reg          irq_fall_q,
   output reg          irq_level_q
);
   reg cnt_cur_q;
   reg irq_prev_q;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_cur_q    <= 1'b0;
         irq_prev_q   <= 1'b1;
         irq_level_q  <= 1'b1;
         count_fall_q <= 1'b0;
         irq_fall_q   <= 1'b0;
      end else begin
         count_fall_q <= 1'b0;
         irq_fall_q   <= 1'b0;
         if (mc_tick) begin
            cnt_cur_q    <= count_pin;
            irq_prev_q   <= irq_pin;
            irq_level_q  <= irq_pin;
            count_fall_q <= cnt_cur_q & ~count_pin;
            irq_fall_q   <= irq_prev_q & ~irq_pin;
         end
      end
   end
endmodule
`default_nettype wire

// >>> hdl/dtc_top.v
// Purpose: Two timer/counters with control and mode registers over APB.
// Assumes: APB3 slave, pready high for one pclk after each setup phase, pins synchronous to pclk.
// Notes:   Interrupt acknowledge inputs clear the hardware-cleared flags.
`timescale 1ns/10ps
`default_nettype none
`include "dtc_defines.vh"
// Notes on behaviour
// - Timer function counts every machine cycle.
// - Counter function counts sampled high-then-low.
// - Edge counted the machine cycle after detection.
// - Overflow flags set by overflow, cleared on vector.
// - Run bits switch each timer.
// - Interrupt edge flags set, cleared when processed.
// - Type bits choose falling-edge or low-level.
// - Select bit and two-bit mode per timer.
// - Modes 0-2 shared; mode 3 differs.
// - Mode 0 uses high byte plus five bits.
// - Mode 0 flags on all-ones rollover.
// - Count enabled by run and gate-or-pin.
// - Setting run keeps count contents.
// - Each timer has own gate and signals.
// - Mode 1 cascades full sixteen bits.
// - Mode field holds gate, select, mode.
// - Mode 2 reloads low from high.
// - Timer one mode 3 holds count.
// - Timer zero mode 3 splits in two.
module dtc_top (
   // Clock and reset
   input  wire         pclk,
   input  wire         presetn,
   // APB
   input  wire         psel,
   input  wire         penable,
   input  wire         pwrite,
   input  wire [11:0]  paddr,
   input  wire [31:0]  pwdata,
   output reg  [31:0]  prdata,
   output reg          pready,
   output reg          pslverr,
   // Pins
   input  wire         first_count_pin,
   input  wire         second_count_pin,
   input  wire         ext_irq_a_pin,
   input  wire         ext_irq_b_pin,
   // Interrupt acknowledges
   input  wire         first_timer_vector_ack,
   input  wire         second_timer_vector_ack,
   input  wire         ext_irq_a_ack,
   input  wire         ext_irq_b_ack,
   // Interrupt requests
   output reg          first_timer_irq_q,
   output reg          second_timer_irq_q,
   output reg          ext_irq_a_req_q,
   output reg          ext_irq_b_req_q
);
   reg  [7:0] ctrl_q;
   reg  [7:0] mode_q;
   reg  [7:0] t0l_q;
   reg  [7:0] t0h_q;
   reg  [7:0] t1l_q;
   reg  [7:0] t1h_q;
   reg  [7:0] ctrl_d;
   reg  [7:0] t0l_d;
   reg  [7:0] t0h_d;
   reg  [7:0] t1l_d;
   reg  [7:0] t1h_d;
   reg        ovf0;
   reg        ovf1;
   wire       mc_tick;
   wire       c0_fall;
   wire       c1_fall;
   wire       i0_fall;
   wire       i1_fall;
   wire       i0_lvl;
   wire       i1_lvl;
   wire       wr_en;
   wire [3:0] m0;
   wire [3:0] m1;
   wire       en0;
   wire       en1;
   wire       en0h;
   wire       inc0;
   wire       inc1;
   wire       inc0h;

   dtc_mc_timebase u_tb (
      .pclk      (pclk),
      .presetn   (presetn),
      .mc_tick_q (mc_tick)
   );

   dtc_pin_sampler u_s0 (
      .pclk         (pclk),
      .presetn      (presetn),
      .mc_tick      (mc_tick),
      .count_pin    (first_count_pin),
      .irq_pin      (ext_irq_a_pin),
      .count_fall_q (c0_fall),
      .irq_fall_q   (i0_fall),
      .irq_level_q  (i0_lvl)
   );

   dtc_pin_sampler u_s1 (
      .pclk         (pclk),
      .presetn      (presetn),
      .mc_tick      (mc_tick),
      .count_pin    (second_count_pin),
      .irq_pin      (ext_irq_b_pin),
      .count_fall_q (c1_fall),
      .irq_fall_q   (i1_fall),
      .irq_level_q  (i1_lvl)
   );

   assign wr_en = psel & penable & pwrite;
   assign m0    = mode_q[3:0];
   assign m1    = mode_q[7:4];

   // Count enables from run bit, gate bit and interrupt pin.
   assign en0  = ctrl_q[`DTC_BIT_TR0] & (~m0[`DTC_MOD_GATE] | i0_lvl);
   assign en1  = ctrl_q[`DTC_BIT_TR1] & (~m1[`DTC_MOD_GATE] | i1_lvl)
                 & (m1[1:0] != `DTC_MODE_SPLIT);
   assign en0h = ctrl_q[`DTC_BIT_TR1];

   // Timer ticks on each machine cycle, counter on a detected fall.
   assign inc0  = en0 & (m0[`DTC_MOD_CT] ? c0_fall : mc_tick);
   assign inc1  = en1 & (m1[`DTC_MOD_CT] ? c1_fall : mc_tick);
   assign inc0h = en0h & mc_tick & (m0[1:0] == `DTC_MODE_SPLIT);

   always @* begin
      ctrl_d = ctrl_q;
      t0l_d  = t0l_q;
      t0h_d  = t0h_q;
      t1l_d  = t1l_q;
      t1h_d  = t1h_q;
      ovf0   = 1'b0;
      ovf1   = 1'b0;
      // Software writes land first, hardware updates override.
      if (wr_en) begin
         case (paddr)
            `DTC_OFF_CTRL: begin
               ctrl_d = pwdata[7:0];
            end
            `DTC_OFF_T0_LOW: begin
               t0l_d = pwdata[7:0];
            end
            `DTC_OFF_T0_HIGH: begin
               t0h_d = pwdata[7:0];
            end
            `DTC_OFF_T1_LOW: begin
               t1l_d = pwdata[7:0];
            end
            `DTC_OFF_T1_HIGH: begin
               t1h_d = pwdata[7:0];
            end
            default: begin
            end
         endcase
      end
      // Timer zero, modes 0 to 3.
      if (inc0) begin
         case (m0[1:0])
            `DTC_MODE_13BIT: begin
               t0l_d = {t0l_q[7:5], t0l_q[4:0] + 5'h01};
               if (t0l_q[4:0] == 5'h1F) begin
                  t0h_d = t0h_q + 8'h01;
                  ovf0  = (t0h_q == 8'hFF);
               end
            end
            `DTC_MODE_16BIT: begin
               t0l_d = t0l_q + 8'h01;
               if (t0l_q == 8'hFF) begin
                  t0h_d = t0h_q + 8'h01;
                  ovf0  = (t0h_q == 8'hFF);
               end
            end
            `DTC_MODE_RELOAD: begin
               if (t0l_q == 8'hFF) begin
                  t0l_d = t0h_q;
                  ovf0  = 1'b1;
               end else begin
                  t0l_d = t0l_q + 8'h01;
               end
            end
            default: begin
               t0l_d = t0l_q + 8'h01;
               ovf0  = (t0l_q == 8'hFF);
            end
         endcase
      end
      if (inc0h) begin
         t0h_d = t0h_q + 8'h01;
         ovf1  = (t0h_q == 8'hFF);
      end
      // Timer one, modes 0 to 2; mode 3 never enables.
      if (inc1) begin
         case (m1[1:0])
            `DTC_MODE_13BIT: begin
               t1l_d = {t1l_q[7:5], t1l_q[4:0] + 5'h01};
               if (t1l_q[4:0] == 5'h1F) begin
                  t1h_d = t1h_q + 8'h01;
                  ovf1  = ovf1 | (t1h_q == 8'hFF);
               end
            end
            `DTC_MODE_16BIT: begin
               t1l_d = t1l_q + 8'h01;
               if (t1l_q == 8'hFF) begin
                  t1h_d = t1h_q + 8'h01;
                  ovf1  = ovf1 | (t1h_q == 8'hFF);
               end
            end
            default: begin
               if (t1l_q == 8'hFF) begin
                  t1l_d = t1h_q;
                  ovf1  = 1'b1;
               end else begin
                  t1l_d = t1l_q + 8'h01;
               end
            end
         endcase
      end
      // Flag clears by acknowledge; a set in the same cycle wins.
      if (first_timer_vector_ack) begin
         ctrl_d[`DTC_BIT_TF0] = 1'b0;
      end
      if (second_timer_vector_ack) begin
         ctrl_d[`DTC_BIT_TF1] = 1'b0;
      end
      if (ext_irq_a_ack & ctrl_q[`DTC_BIT_IT0]) begin
         ctrl_d[`DTC_BIT_IE0] = 1'b0;
      end
      if (ext_irq_b_ack & ctrl_q[`DTC_BIT_IT1]) begin
         ctrl_d[`DTC_BIT_IE1] = 1'b0;
      end
      if (ovf0) begin
         ctrl_d[`DTC_BIT_TF0] = 1'b1;
      end
      if (ovf1) begin
         ctrl_d[`DTC_BIT_TF1] = 1'b1;
      end
      // Edge mode latches falls; level mode follows the low pin.
      if (ctrl_q[`DTC_BIT_IT0]) begin
         if (i0_fall) begin
            ctrl_d[`DTC_BIT_IE0] = 1'b1;
         end
      end else begin
         ctrl_d[`DTC_BIT_IE0] = ~i0_lvl;
      end
      if (ctrl_q[`DTC_BIT_IT1]) begin
         if (i1_fall) begin
            ctrl_d[`DTC_BIT_IE1] = 1'b1;
         end
      end else begin
         ctrl_d[`DTC_BIT_IE1] = ~i1_lvl;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q             <= `DTC_CTRL_RESET;
         mode_q             <= `DTC_MODE_RESET;
         t0l_q              <= 8'h00;
         t0h_q              <= 8'h00;
         t1l_q              <= 8'h00;
         t1h_q              <= 8'h00;
         prdata             <= 32'h00000000;
         pready             <= 1'b0;
         pslverr            <= 1'b0;
         first_timer_irq_q  <= 1'b0;
         second_timer_irq_q <= 1'b0;
         ext_irq_a_req_q    <= 1'b0;
         ext_irq_b_req_q    <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         t0l_q  <= t0l_d;
         t0h_q  <= t0h_d;
         t1l_q  <= t1l_d;
         t1h_q  <= t1h_d;
         if (wr_en && paddr == `DTC_OFF_MODE) begin
            mode_q <= pwdata[7:0];
         end
         first_timer_irq_q  <= ctrl_d[`DTC_BIT_TF0];
         second_timer_irq_q <= ctrl_d[`DTC_BIT_TF1];
         ext_irq_a_req_q    <= ctrl_d[`DTC_BIT_IE0];
         ext_irq_b_req_q    <= ctrl_d[`DTC_BIT_IE1];
         pready  <= psel & ~penable;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
         if (psel && !penable) begin
            case (paddr)
               `DTC_OFF_CTRL: begin
                  prdata <= {24'h000000, ctrl_q};
               end
               `DTC_OFF_MODE: begin
                  prdata <= {24'h000000, mode_q};
               end
               `DTC_OFF_T0_LOW: begin
                  prdata <= {24'h000000, t0l_q};
               end
               `DTC_OFF_T0_HIGH: begin
                  prdata <= {24'h000000, t0h_q};
               end
               `DTC_OFF_T1_LOW: begin
                  prdata <= {24'h000000, t1l_q};
               end
               `DTC_OFF_T1_HIGH: begin
                  prdata <= {24'h000000, t1h_q};
               end
               default: begin
                  pslverr <= 1'b1;
               end
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// >>> verification/dtc_top_assertions.sv
// Purpose: Port assertions for dtc_top.
// Assumes: Run bits are shadowed from APB writes to the control register.
// Notes:   Bound to every dtc_top instance.
`timescale 1ns/10ps
`default_nettype none
module dtc_chk (
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Pins and interrupts
   input wire logic        ext_irq_a_pin,
   input wire logic        first_timer_vector_ack,
   input wire logic        second_timer_vector_ack,
   input wire logic        first_timer_irq_q,
   input wire logic        second_timer_irq_q,
   input wire logic        ext_irq_a_req_q
);
   logic [7:0] ctl_q;
   logic [5:0] age_q;
   wire        wr = psel && penable && pwrite && pready && paddr == 12'h000;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_q <= 8'h00;
         age_q <= 6'h3F;
      end else begin
         if (wr)
            ctl_q <= pwdata[7:0];
         age_q <= !ext_irq_a_pin ? 6'h00 : age_q + {5'h00, age_q != 6'h3F};
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_SETUP: assert property (psel && !penable |=> pready)
      else $error("pready missing after setup");
   AST_ACCESS: assert property (pready |-> psel && penable)
      else $error("pready outside access");
   AST_UNMAP: assert property (pready && paddr == 12'h018 |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   AST_HIGH: assert property (pready |-> prdata[31:8] == 24'h0)
      else $error("upper read bits set");
   AST_TF0_ACK: assert property (first_timer_vector_ack && !ctl_q[4] && !wr |=> !first_timer_irq_q)
      else $error("timer zero flag kept after ack");
   AST_TF1_ACK: assert property (second_timer_vector_ack && !ctl_q[6] && !wr |=> !second_timer_irq_q)
      else $error("timer one flag kept after ack");
   AST_TF0_RUN: assert property ($rose(first_timer_irq_q) |-> $past(ctl_q[4]) || $past(wr))
      else $error("timer zero overflow while stopped");
   AST_TF1_RUN: assert property ($rose(second_timer_irq_q) |-> $past(ctl_q[6]) || $past(wr))
      else $error("timer one overflow while stopped");
   AST_EDGE_A: assert property ($rose(ext_irq_a_req_q) && !$past(wr) |-> age_q < 6'd40)
      else $error("interrupt flag without low pin");
   COV_WR: cover property (wr);
   COV_TF0: cover property ($rose(first_timer_irq_q));
   COV_IRQ: cover property ($rose(ext_irq_a_req_q));
endmodule
bind dtc_top dtc_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .ext_irq_a_pin(ext_irq_a_pin),
   .first_timer_vector_ack(first_timer_vector_ack),
   .second_timer_vector_ack(second_timer_vector_ack),
   .first_timer_irq_q(first_timer_irq_q), .second_timer_irq_q(second_timer_irq_q),
   .ext_irq_a_req_q(ext_irq_a_req_q));
`default_nettype wire

// >>> verification/dtc_pins_model.sv
// Purpose: External pin source for the count and interrupt pins.
// Assumes: Twelve pclk periods per machine cycle.
// Notes:   Both count pins idle high and make the commanded number of falls.
`timescale 1ns/10ps
`default_nettype none
module dtc_pins_model (
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Commands
   input  wire logic [7:0] n_fall,
   input  wire logic       go,
   input  wire logic       irq_a,
   input  wire logic       irq_b,
   // Pins
   output var logic        first_count_pin,
   output wire logic       second_count_pin,
   output wire logic       ext_irq_a_pin,
   output wire logic       ext_irq_b_pin
);
   logic [3:0] div_q;
   logic [8:0] left_q;
   assign second_count_pin = first_count_pin;
   assign ext_irq_a_pin = irq_a;
   assign ext_irq_b_pin = irq_b;
   // Each level is held one full machine cycle.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= 4'h0;
         left_q <= 9'h000;
         first_count_pin <= 1'b1;
      end else begin
         div_q <= (div_q == 4'hB) ? 4'h0 : div_q + 4'h1;
         if (go)
            left_q <= {n_fall, 1'b0};
         else if (div_q == 4'hB && left_q != 9'h000) begin
            first_count_pin <= !first_count_pin;
            left_q <= left_q - 9'h001;
         end
      end
   end
endmodule
`default_nettype wire

// >>> verification/dtc_top_tb.sv
// Purpose: Self-checking bench for dtc_top.
// Assumes: The APB master waits for pready at a rising edge.
// Notes:   Run windows are whole machine cycles between write landings.
`timescale 1ns/10ps
`default_nettype none
module dtc_top_tb;
   logic        pclk, presetn, psel, penable, pwrite, err, go, irq_a, irq_b;
   logic        ack0, ack1, acka, ackb;
   logic [11:0] paddr;
   logic [31:0] pwdata, rd;
   logic [7:0]  n_fall;
   wire         pready, pslverr, cp0, cp1, pa, pb, i0, i1, ra, rb;
   wire  [31:0] prdata;
   int          miscompares, n_compared;
   logic [52:0] row [7] = '{{12'h000, 32'h00000005, 8'h05, 1'b0},
      {12'h004, 32'hFFFFFF5A, 8'h5A, 1'b0}, {12'h008, 32'h000000C3, 8'hC3, 1'b0},
      {12'h00C, 32'h0000013C, 8'h3C, 1'b0}, {12'h010, 32'h000000E1, 8'hE1, 1'b0},
      {12'h014, 32'h0000001E, 8'h1E, 1'b0}, {12'h018, 32'h000000FF, 8'h00, 1'b1}};
   dtc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .first_count_pin(cp0), .second_count_pin(cp1),
      .ext_irq_a_pin(pa), .ext_irq_b_pin(pb), .first_timer_vector_ack(ack0),
      .second_timer_vector_ack(ack1), .ext_irq_a_ack(acka), .ext_irq_b_ack(ackb),
      .first_timer_irq_q(i0), .second_timer_irq_q(i1), .ext_irq_a_req_q(ra),
      .ext_irq_b_req_q(rb));
   dtc_pins_model i_pins (.pclk(pclk), .presetn(presetn), .n_fall(n_fall), .go(go),
      .irq_a(irq_a), .irq_b(irq_b), .first_count_pin(cp0), .second_count_pin(cp1),
      .ext_irq_a_pin(pa), .ext_irq_b_pin(pb));
   task automatic end_sim();
      if (miscompares == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      cmp(rd, e);
   endtask
   task automatic look(input int n);
      repeat (n) @(posedge pclk);
      @(negedge pclk);
   endtask
   task automatic ack(input int s);
      @(posedge pclk);
      {ackb, acka, ack1, ack0} <= 4'h1 << s;
      @(posedge pclk);
      {ackb, acka, ack1, ack0} <= 4'h0;
      look(2);
   endtask
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   initial begin
      repeat (20000) @(posedge pclk);
      miscompares++;
      end_sim();
   end
   initial begin
      {presetn, psel, penable, pwrite, go, ack0, ack1, acka, ackb} = 9'h000;
      {irq_a, irq_b} = 2'h3;
      paddr = 12'h000;
      pwdata = 32'h0;
      n_fall = 8'h00;
      miscompares = 0;
      n_compared = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      for (int a = 0; a < 24; a += 4) rchk(a[11:0], 32'h0);
      foreach (row[i]) begin
         wr(row[i][52:41], row[i][40:9]);
         apb(1'b0, row[i][52:41], 32'h0);
         cmp(rd, {24'h0, row[i][8:1]});
         cmp(err, row[i][0]);
      end
      wr(12'h008, 32'hF0);
      wr(12'h00C, 32'h00);
      wr(12'h004, 32'h01);
      wr(12'h000, 32'h10);
      repeat (237) @(posedge pclk);
      wr(12'h000, 32'h00);
      rchk(12'h008, 32'h04);
      rchk(12'h00C, 32'h01);
      wr(12'h000, 32'h10);
      repeat (21) @(posedge pclk);
      wr(12'h000, 32'h00);
      rchk(12'h008, 32'h06);
      wr(12'h00C, 32'hFF);
      wr(12'h008, 32'h1E);
      wr(12'h004, 32'h00);
      wr(12'h000, 32'h10);
      repeat (33) @(posedge pclk);
      look(0);
      cmp(i0, 1'b1);
      wr(12'h000, 32'h20);
      rchk(12'h00C, 32'h00);
      rchk(12'h008, 32'h01);
      rchk(12'h000, 32'h20);
      ack(0);
      cmp(i0, 1'b0);
      wr(12'h014, 32'h80);
      wr(12'h010, 32'hFE);
      wr(12'h004, 32'h20);
      wr(12'h000, 32'h40);
      repeat (45) @(posedge pclk);
      look(0);
      cmp(i1, 1'b1);
      wr(12'h000, 32'h80);
      rchk(12'h010, 32'h82);
      rchk(12'h014, 32'h80);
      ack(1);
      cmp(i1, 1'b0);
      wr(12'h008, 32'h00);
      wr(12'h010, 32'h00);
      wr(12'h004, 32'h55);
      wr(12'h000, 32'h50);
      n_fall <= 8'h05;
      go <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      repeat (170) @(posedge pclk);
      rchk(12'h008, 32'h05);
      rchk(12'h010, 32'h05);
      irq_b <= 1'b0;
      repeat (12) @(posedge pclk);
      look(0);
      cmp(rb, 1'b1);
      wr(12'h010, 32'h00);
      wr(12'h014, 32'h00);
      wr(12'h004, 32'h90);
      wr(12'h000, 32'h40);
      repeat (237) @(posedge pclk);
      wr(12'h000, 32'h00);
      rchk(12'h010, 32'h00);
      irq_b <= 1'b1;
      repeat (12) @(posedge pclk);
      look(0);
      cmp(rb, 1'b0);
      wr(12'h000, 32'h40);
      repeat (237) @(posedge pclk);
      wr(12'h000, 32'h00);
      rchk(12'h010, 32'h14);
      wr(12'h00C, 32'hF0);
      wr(12'h008, 32'h00);
      wr(12'h010, 32'h33);
      wr(12'h004, 32'h33);
      wr(12'h000, 32'h40);
      repeat (237) @(posedge pclk);
      look(0);
      cmp({i1, i0}, 2'h2);
      wr(12'h000, 32'h80);
      rchk(12'h00C, 32'h04);
      rchk(12'h008, 32'h00);
      rchk(12'h010, 32'h33);
      wr(12'h000, 32'h01);
      irq_a <= 1'b0;
      repeat (24) @(posedge pclk);
      irq_a <= 1'b1;
      look(36);
      cmp(ra, 1'b1);
      ack(2);
      cmp(ra, 1'b0);
      wr(12'h000, 32'h00);
      irq_a <= 1'b0;
      look(36);
      cmp(ra, 1'b1);
      @(posedge pclk);
      irq_a <= 1'b1;
      look(36);
      cmp(ra, 1'b0);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rchk(12'h004, 32'h00);
      rchk(12'h00C, 32'h00);
      end_sim();
   end
endmodule
`default_nettype wire
